// ===== shared/dwb_pkg.sv
`default_nettype none
package dwb_pkg;
  // Geometry
  localparam int LANE_BITS = 8;
  localparam int BEATS = 8;
  localparam int CHOP_BEATS = 4;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int COL_W = 6;
  localparam int LAT_W = 5;
  localparam int DEV_WIDTH = 16;
  // Burst field of mode_register_zero
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_PER_COMMAND = 2'h1;
  localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_LAT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MEM_INDEX = 8'h0c;
  localparam logic [7:0] OFS_MEM_DATA = 8'h10;
  // Mode register fields
  localparam int MODE_BURST_LSB = 0;
  localparam int MODE_MASK_EN = 2;
  localparam int MODE_DBI_EN = 3;
  localparam int MODE_CRC_EN = 4;
  localparam int MODE_CAL_EN = 5;
  localparam int MODE_W = 6;
  // Latency register fields
  localparam int LAT_CWL_LSB = 0;
  localparam int LAT_AL_LSB = 5;
  // Status register fields
  localparam int ST_DLL_LOCKED = 0;
  localparam int ST_CRC_PERSIST = 1;
  localparam int ST_LAST_CHOP = 2;
  localparam int ST_LAST_CLOSE = 3;
  localparam int ST_STRAY = 4;
  localparam int ST_BANK_LSB = 8;
  // Reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
  localparam logic [9:0] LAT_RESET = 10'h009;
endpackage : dwb_pkg
`default_nettype wire

// ===== design/dwb_write_path.sv
`default_nettype none
module dwb_write_path #(
  parameter int LANES = dwb_pkg::DEV_WIDTH / dwb_pkg::LANE_BITS,
  parameter int MEM_DEPTH = 64
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Command pins
  input wire logic cmd_activate,
  input wire logic cmd_write,
  input wire logic [dwb_pkg::BANK_W-1:0] cmd_bank,
  input wire logic [dwb_pkg::COL_W-1:0] cmd_col,
  input wire logic auto_close_address_bit,
  input wire logic burst_chop_address_bit,
  input wire logic on_die_termination_control,
  input wire logic dll_locked,
  // Data link, on the strobe clock
  input wire logic link_clk,
  input wire logic beat_valid,
  input wire logic [LANES*dwb_pkg::LANE_BITS-1:0] beat_data,
  input wire logic [LANES-1:0] byte_lane_write_mask,
  // Status outputs
  output logic termination_active,
  output logic burst_stored
);
  import dwb_pkg::*;
  localparam int DW = LANES * LANE_BITS;
  localparam int IDX_W = $clog2(MEM_DEPTH);
  localparam int BW = $clog2(BEATS);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DUE} dwb_state_t;
  function automatic logic chop_sel(input logic [1:0] field, input logic a12);
    chop_sel = (field == BURST_FIXED_CHOP) || ((field == BURST_PER_COMMAND) && !a12);
  endfunction : chop_sel
  // Masking on every part built from eight bit lanes, whatever the number of lanes
  localparam logic MASK_PRESENT = (LANE_BITS == 8) && (LANES >= 1);
  // Link domain: gather one burst of beats
  logic [BW-1:0] beat_cnt_ff;
  logic [DW-1:0] beat_buf_ff [BEATS];
  logic [LANES-1:0] mask_buf_ff [BEATS];
  logic burst_tgl_ff;
  // Toggle on the edge that takes the last beat; no later link edge is needed
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      beat_cnt_ff <= '0;
      burst_tgl_ff <= 1'b0;
    end
    else if (beat_valid)
    begin
      beat_cnt_ff <= beat_cnt_ff + 1'b1;
      if (beat_cnt_ff == BW'(BEATS - 1))
        burst_tgl_ff <= ~burst_tgl_ff;
    end
  end
  always_ff @(posedge link_clk)
  begin
    if (beat_valid)
    begin
      beat_buf_ff[beat_cnt_ff] <= beat_data;
      mask_buf_ff[beat_cnt_ff] <= byte_lane_write_mask;
    end
  end
  // Core domain: pin synchronisers
  localparam int SW = 6 + BANK_W + COL_W;
  logic [SW-1:0] pin_s1_ff;
  logic [SW-1:0] pin_s2_ff;
  logic [2:0] tgl_sync_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      tgl_sync_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= {cmd_activate, cmd_write, auto_close_address_bit, burst_chop_address_bit,
                    on_die_termination_control, dll_locked, cmd_bank, cmd_col};
      pin_s2_ff <= pin_s1_ff;
      tgl_sync_ff <= {tgl_sync_ff[1:0], burst_tgl_ff};
    end
  end
  logic s_act;
  logic s_wr;
  logic s_a10;
  logic s_a12;
  logic s_odt;
  logic s_dll;
  logic [BANK_W-1:0] s_bank;
  logic [COL_W-1:0] s_col;
  assign {s_act, s_wr, s_a10, s_a12, s_odt, s_dll, s_bank, s_col} = pin_s2_ff;
  wire burst_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];
  // Registers
  logic [MODE_W-1:0] mode_ff;
  logic [9:0] lat_ff;
  logic [IDX_W-1:0] mem_idx_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= MODE_RESET;
      lat_ff <= LAT_RESET;
      mem_idx_ff <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_MODE)
        mode_ff <= reg_wdata[MODE_W-1:0];
      if (reg_addr == OFS_LAT)
        lat_ff <= reg_wdata[9:0];
      if (reg_addr == OFS_MEM_INDEX)
        mem_idx_ff <= reg_wdata[IDX_W-1:0];
    end
  end
  wire [1:0] burst_field = mode_ff[MODE_BURST_LSB +: 2];
  wire mask_en = mode_ff[MODE_MASK_EN];
  wire dbi_en = mode_ff[MODE_DBI_EN];
  wire crc_en = mode_ff[MODE_CRC_EN];
  // Write latency in clocks, never below one
  wire [LAT_W:0] wl_sum = {1'b0, lat_ff[LAT_CWL_LSB +: LAT_W]} +
                          {1'b0, lat_ff[LAT_AL_LSB +: LAT_W]};
  wire [LAT_W:0] wl_val = (wl_sum == '0) ? (LAT_W+1)'(1) : wl_sum;
  // Command tracking
  dwb_state_t state_ff;
  logic [LAT_W:0] wl_cnt_ff;
  logic pend_chop_ff;
  logic pend_close_ff;
  logic [BANK_W-1:0] pend_bank_ff;
  logic [COL_W-1:0] pend_col_ff;
  wire cmd_take = s_wr && s_dll && (state_ff == ST_IDLE);
  wire store = burst_evt && (state_ff == ST_DUE);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      wl_cnt_ff <= '0;
      pend_chop_ff <= 1'b0;
      pend_close_ff <= 1'b0;
      pend_bank_ff <= '0;
      pend_col_ff <= '0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (cmd_take)
          begin
            state_ff <= ST_WAIT;
            wl_cnt_ff <= wl_val;
            pend_chop_ff <= chop_sel(burst_field, s_a12);
            pend_close_ff <= s_a10;
            pend_bank_ff <= s_bank;
            pend_col_ff <= s_col;
          end
        end
        ST_WAIT:
        begin
          wl_cnt_ff <= wl_cnt_ff - 1'b1;
          if (wl_cnt_ff == (LAT_W+1)'(1))
            state_ff <= ST_DUE;
        end
        ST_DUE:
        begin
          if (store)
            state_ff <= ST_IDLE;
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
  // Bank state and burst results
  logic [BANKS-1:0] bank_open_ff;
  logic last_chop_ff;
  logic last_close_ff;
  logic stray_ff;
  logic stored_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_open_ff <= '0;
      last_chop_ff <= 1'b0;
      last_close_ff <= 1'b0;
      stray_ff <= 1'b0;
      stored_ff <= 1'b0;
    end
    else
    begin
      stored_ff <= store;
      if (burst_evt && !store)
        stray_ff <= 1'b1;
      else if (reg_wr && (reg_addr == OFS_STATUS) && reg_wdata[ST_STRAY])
        stray_ff <= 1'b0;
      if (s_act)
        bank_open_ff[s_bank] <= 1'b1;
      if (store)
      begin
        last_chop_ff <= pend_chop_ff;
        last_close_ff <= pend_close_ff;
        if (pend_close_ff)
          bank_open_ff[pend_bank_ff] <= 1'b0;
      end
    end
  end
  // Lane enables; inversion owns the shared pin, so masking then does nothing
  logic [LANES-1:0] lane_we [BEATS];
  always_comb
  begin
    for (int b = 0; b < BEATS; b++)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        lane_we[b][l] = store && (!pend_chop_ff || (b < CHOP_BEATS));
        if (MASK_PRESENT && mask_en && !dbi_en && !mask_buf_ff[b][l])
          lane_we[b][l] = 1'b0;
      end
    end
  end
  // Memory core, beats stored at consecutive words from the column
  logic [DW-1:0] mem [MEM_DEPTH];
  always_ff @(posedge clock)
  begin
    for (int b = 0; b < BEATS; b++)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (lane_we[b][l])
          mem[IDX_W'(pend_col_ff) + IDX_W'(b)][l*LANE_BITS +: LANE_BITS] <=
            beat_buf_ff[b][l*LANE_BITS +: LANE_BITS];
      end
    end
  end
  // CRC mode follows the mask enable
  logic crc_persist_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      crc_persist_ff <= 1'b0;
    else
      crc_persist_ff <= crc_en && mask_en;
  end
  // Termination follows the command bus directly; the CAL setting is not consulted
  logic term_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      term_ff <= 1'b0;
    else
      term_ff <= s_odt;
  end
  // Read port, answer one cycle later
  logic [31:0] rdata_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_MODE: rdata_ff <= 32'(mode_ff);
        OFS_LAT: rdata_ff <= 32'(lat_ff);
        OFS_STATUS: rdata_ff <= 32'({bank_open_ff, 3'h0, stray_ff, last_close_ff,
                                     last_chop_ff, crc_persist_ff, s_dll});
        OFS_MEM_INDEX: rdata_ff <= 32'(mem_idx_ff);
        OFS_MEM_DATA: rdata_ff <= 32'(mem[mem_idx_ff]);
        default: rdata_ff <= '0;
      endcase
    end
    else
      rdata_ff <= '0;
  end
  assign reg_rdata = rdata_ff;
  assign termination_active = term_ff;
  assign burst_stored = stored_ff;
  // Checks
  property p_fixed_eight;
    @(posedge clock) disable iff (!rst_n)
    cmd_take && burst_field == BURST_FIXED_EIGHT |=> !pend_chop_ff;
  endproperty
  a_fixed_eight: assert property (p_fixed_eight) else $error("fixed eight chopped");
  property p_per_command;
    @(posedge clock) disable iff (!rst_n)
    cmd_take && burst_field == BURST_PER_COMMAND |=> pend_chop_ff == !$past(s_a12);
  endproperty
  a_per_command: assert property (p_per_command) else $error("chop bit misread");
  property p_fixed_chop;
    @(posedge clock) disable iff (!rst_n)
    cmd_take && burst_field == BURST_FIXED_CHOP |=> pend_chop_ff;
  endproperty
  a_fixed_chop: assert property (p_fixed_chop) else $error("fixed chop lost");
  property p_open_kept;
    @(posedge clock) disable iff (!rst_n)
    store && !pend_close_ff && bank_open_ff[pend_bank_ff] |=> bank_open_ff[$past(pend_bank_ff)];
  endproperty
  a_open_kept: assert property (p_open_kept) else $error("bank closed on write");
  property p_auto_close;
    @(posedge clock) disable iff (!rst_n)
    store && pend_close_ff && !s_act |=> !bank_open_ff[$past(pend_bank_ff)];
  endproperty
  a_auto_close: assert property (p_auto_close) else $error("bank not closed");
  property p_chop_tail;
    @(posedge clock) disable iff (!rst_n)
    store && pend_chop_ff |-> lane_we[CHOP_BEATS] == '0 && lane_we[BEATS-1] == '0;
  endproperty
  a_chop_tail: assert property (p_chop_tail) else $error("chop tail stored");
  property p_mask_low;
    @(posedge clock) disable iff (!rst_n)
    store && mask_en && !dbi_en && !mask_buf_ff[1][LANES-1] |-> !lane_we[1][LANES-1];
  endproperty
  a_mask_low: assert property (p_mask_low) else $error("masked lane written");
  property p_crc_mode;
    @(posedge clock) disable iff (!rst_n)
    $stable(mode_ff) ##1 $stable(mode_ff) |-> crc_persist_ff == (crc_en && mask_en);
  endproperty
  a_crc_mode: assert property (p_crc_mode) else $error("crc mode wrong");
  property p_term;
    @(posedge clock) disable iff (!rst_n)
    ##1 term_ff == $past(s_odt);
  endproperty
  a_term: assert property (p_term) else $error("termination shifted");
  property p_latency;
    @(posedge clock) disable iff (!rst_n)
    cmd_take |=> state_ff == ST_WAIT ##0 wl_cnt_ff == $past(wl_val);
  endproperty
  a_latency: assert property (p_latency) else $error("write latency wrong");
  property p_lock;
    @(posedge clock) disable iff (!rst_n)
    state_ff == ST_IDLE && !s_dll |=> state_ff == ST_IDLE;
  endproperty
  a_lock: assert property (p_lock) else $error("write taken unlocked");
endmodule : dwb_write_path
`default_nettype wire

// ===== verif/dwb_ctrl_model.sv
`default_nettype none
module dwb_ctrl_model #(
  parameter int W = 16,
  parameter int L = 2
) (
  // Link side driven by the controller
  output logic link_clk,
  output logic beat_valid,
  output logic [W-1:0] beat_data,
  output logic [L-1:0] byte_lane_write_mask
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    link_clk = 1'b0;
    beat_valid = 1'b0;
    beat_data = '0;
    byte_lane_write_mask = '1;
  end
  // Strobe clock runs only inside a burst; idle lines show inverted junk
  task automatic send_burst(input logic [W-1:0] base, input logic [L-1:0] m0,
    input logic [L-1:0] m1);
    for (int b = 0; b < 8; b++)
    begin
      beat_valid = 1'b1;
      beat_data = base + W'(b);
      byte_lane_write_mask = b[0] ? m1 : m0;
      #15 link_clk = 1'b1;
      #15 link_clk = 1'b0;
    end
    beat_valid = 1'b0;
    beat_data = ~beat_data;
    byte_lane_write_mask = ~byte_lane_write_mask;
  endtask : send_burst
endmodule : dwb_ctrl_model
`default_nettype wire

// ===== verif/dwb_write_path_bench.sv
`default_nettype none
module dwb_write_path_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dwb_pkg::*;
  logic clock, rst_n, reg_wr, reg_rd, cmd_activate, cmd_write;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [BANK_W-1:0] cmd_bank;
  logic [COL_W-1:0] cmd_col;
  logic auto_close_address_bit, burst_chop_address_bit, on_die_termination_control;
  logic dll_locked, link_clk, beat_valid, termination_active, burst_stored;
  logic [15:0] beat_data;
  logic [1:0] byte_lane_write_mask;
  logic [15:0] exp_mem [8];
  int failures, tests_run, t0;
  dwb_write_path dwb_write_path_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_activate(cmd_activate), .cmd_write(cmd_write), .cmd_bank(cmd_bank),
    .cmd_col(cmd_col), .auto_close_address_bit(auto_close_address_bit),
    .burst_chop_address_bit(burst_chop_address_bit),
    .on_die_termination_control(on_die_termination_control), .dll_locked(dll_locked),
    .link_clk(link_clk), .beat_valid(beat_valid), .beat_data(beat_data),
    .byte_lane_write_mask(byte_lane_write_mask), .termination_active(termination_active),
    .burst_stored(burst_stored));
  dwb_ctrl_model dwb_ctrl_model_inst (.link_clk(link_clk), .beat_valid(beat_valid),
    .beat_data(beat_data), .byte_lane_write_mask(byte_lane_write_mask));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic issue(input logic act, input logic [1:0] bk, input logic a10,
    input logic a12);
    @(posedge clock);
    cmd_activate <= act;
    cmd_write <= ~act;
    cmd_bank <= bk;
    auto_close_address_bit <= a10;
    burst_chop_address_bit <= a12;
    repeat (2) @(posedge clock);
    cmd_activate <= 1'b0;
    cmd_write <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : issue
  // Waits wl clocks, sends a burst, then expects a store or none
  task automatic burst(input logic [15:0] base, input logic [1:0] m1, input int wl,
    input bit st, input bit ch);
    int n;
    logic [15:0] w;
    repeat (wl) @(posedge clock);
    dwb_ctrl_model_inst.send_burst(base, 2'h3, m1);
    n = 0;
    while (burst_stored !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1 n++;
    end
    check("burst_stored", 32'(st), 32'(n < 20));
    if (st)
      for (int b = 0; b < (ch ? 4 : 8); b++)
        for (int l = 0; l < 2; l++)
          if (!b[0] || m1[l])
          begin
            w = base + 16'(b);
            exp_mem[b][l*8+:8] = w[l*8+:8];
          end
  endtask : burst
  task automatic check_mem;
    for (int b = 0; b < 8; b++)
    begin
      reg_write(OFS_MEM_INDEX, 32'(b));
      reg_read(OFS_MEM_DATA, rd);
      check("mem word", {16'h0, exp_mem[b]}, {16'h0, rd[15:0]});
    end
  endtask : check_mem
  task automatic complete_run;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #100us failures++;
    complete_run();
  end
  initial
  begin
    logic [7:0] modes;
    logic [3:0] chop_pat;
    logic [3:0] a12_pat;
    modes = {BURST_PER_COMMAND, BURST_PER_COMMAND, BURST_FIXED_CHOP, BURST_FIXED_EIGHT};
    chop_pat = 4'b1010;
    a12_pat = 4'b0110;
    {rst_n, reg_wr, reg_rd, cmd_activate, cmd_write, auto_close_address_bit} = '0;
    {burst_chop_address_bit, on_die_termination_control} = '0;
    {reg_addr, reg_wdata, cmd_bank, cmd_col} = '0;
    dll_locked = 1'b1;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    reg_read(OFS_MODE, rd);
    check("mode reset", 32'(MODE_RESET), rd);
    reg_read(OFS_LAT, rd);
    check("latency reset", 32'(LAT_RESET), rd);
    reg_read(8'h40, rd);
    check("unmapped", 32'h0, rd);
    issue(1'b1, 2'h2, 1'b0, 1'b0);
    // Burst field codes and the per-command chooser; last write closes its bank
    for (int i = 0; i < 4; i++)
    begin
      reg_write(OFS_MODE, 32'(modes[i*2+:2]));
      issue(1'b0, 2'h2, i == 3, a12_pat[i]);
      burst(16'h1100 * 16'(i + 1), 2'h3, 9, 1'b1, chop_pat[i]);
      reg_read(OFS_STATUS, rd);
      check("chop flag", 32'(chop_pat[i]), 32'(rd[2]));
      check("close flag", 32'(i == 3), 32'(rd[3]));
      check("open banks", (i == 3) ? 32'h0 : 32'h4, 32'(rd[11:8]));
      check_mem();
    end
    reg_write(OFS_MODE, 32'h5);
    issue(1'b0, 2'h0, 1'b0, 1'b1);
    burst(16'h5500, 2'h1, 9, 1'b1, 1'b0);
    check_mem();
    for (int c = 0; c < 2; c++)
    begin
      reg_write(OFS_MODE, c ? 32'h14 : 32'h10);
      reg_read(OFS_STATUS, rd);
      check("crc persistent", 32'(c), 32'(rd[1]));
    end
    reg_write(OFS_MODE, 32'h0);
    reg_write(OFS_LAT, 32'h154);
    issue(1'b0, 2'h0, 1'b0, 1'b1);
    burst(16'h7700, 2'h3, 0, 1'b0, 1'b0);
    reg_read(OFS_STATUS, rd);
    check("stray early", 32'h1, 32'(rd[4]));
    reg_write(OFS_STATUS, 32'h10);
    burst(16'h8800, 2'h3, 30, 1'b1, 1'b0);
    check_mem();
    @(posedge clock);
    dll_locked <= 1'b0;
    issue(1'b0, 2'h0, 1'b0, 1'b1);
    reg_read(OFS_STATUS, rd);
    check("dll status", 32'h0, 32'(rd[0]));
    burst(16'h9900, 2'h3, 9, 1'b0, 1'b0);
    check_mem();
    @(posedge clock);
    dll_locked <= 1'b1;
    // Termination delay must not depend on the command latency setting
    for (int c = 0; c < 2; c++)
    begin
      int n;
      reg_write(OFS_MODE, c ? 32'h20 : 32'h0);
      on_die_termination_control <= 1'b1;
      n = 0;
      while (termination_active !== 1'b1 && n < 10)
      begin
        @(posedge clock);
        #1 n++;
      end
      if (c == 0)
        t0 = n;
      check("termination delay", 32'(t0), 32'(n));
      check("termination seen", 32'h1, 32'(n < 5));
      on_die_termination_control <= 1'b0;
      repeat (6) @(posedge clock);
    end
    complete_run();
  end
endmodule : dwb_write_path_bench
`default_nettype wire
